/* File: design/dio_pkg.sv */
package dio_pkg;

   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FS_32 = 32_000;
   localparam int unsigned FS_44 = 44_100;
   localparam int unsigned FS_48 = 48_000;
   localparam int unsigned FS_88 = 88_200;
   localparam int unsigned FS_96 = 96_000;

   typedef enum logic [2:0] {
      RATE_32 = 3'b000,
      RATE_44 = 3'b001,
      RATE_48 = 3'b010,
      RATE_88 = 3'b011,
      RATE_96 = 3'b100
   } dio_rate_t;

   // Word clock half periods in clock cycles.
   localparam logic [15:0] HALF_32 = 16'(CLK_HZ / (2 * FS_32));
   localparam logic [15:0] HALF_44 = 16'(CLK_HZ / (2 * FS_44));
   localparam logic [15:0] HALF_48 = 16'(CLK_HZ / (2 * FS_48));
   localparam logic [15:0] HALF_88 = 16'(CLK_HZ / (2 * FS_88));
   localparam logic [15:0] HALF_96 = 16'(CLK_HZ / (2 * FS_96));

   // Period limits between neighbouring rates, midway in cycles, with outer limits at half the shortest and twice the longest period.
   localparam logic [15:0] LIM_96_88 = 16'((CLK_HZ / FS_96 + CLK_HZ / FS_88) / 2);
   localparam logic [15:0] LIM_88_48 = 16'((CLK_HZ / FS_88 + CLK_HZ / FS_48) / 2);
   localparam logic [15:0] LIM_48_44 = 16'((CLK_HZ / FS_48 + CLK_HZ / FS_44) / 2);
   localparam logic [15:0] LIM_44_32 = 16'((CLK_HZ / FS_44 + CLK_HZ / FS_32) / 2);
   localparam logic [15:0] LIM_MIN = 16'((CLK_HZ / FS_96) / 2);
   localparam logic [15:0] LIM_MAX = 16'(2 * (CLK_HZ / FS_32));

   localparam int unsigned WC_TIMEOUT_US = 1000;
   localparam int unsigned WC_TIMEOUT_CYC = WC_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned MIDI_HOLD_MS = 50;
   localparam int unsigned MIDI_HOLD_CYC = MIDI_HOLD_MS * (CLK_HZ / 1000);

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [9:0] CTRL_RST = 10'h004;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   localparam logic [7:0] CS_BLOCK_LAST = 8'hbf;
   localparam logic [2:0] CS_CON_EMPH_NONE = 3'h0;
   localparam logic [2:0] CS_CON_EMPH_5015 = 3'h1;
   localparam logic [2:0] CS_PRO_EMPH_NONE = 3'h4;
   localparam logic [2:0] CS_PRO_EMPH_5015 = 3'h6;
   localparam logic [3:0] CS_PRO_MODE_2CH = 4'h1;
   localparam logic [2:0] CS_PRO_AUX_AUDIO = 3'h1;
   localparam logic [7:0] CS_CAT_GENERAL = 8'h00;
   localparam logic [3:0] CS_CON_FS_32 = 4'h3;
   localparam logic [3:0] CS_CON_FS_44 = 4'h0;
   localparam logic [3:0] CS_CON_FS_48 = 4'h2;
   localparam logic [3:0] CS_CON_FS_88 = 4'h8;
   localparam logic [3:0] CS_CON_FS_96 = 4'ha;
   localparam logic [1:0] CS_PRO_FS_EXT = 2'h0;
   localparam logic [1:0] CS_PRO_FS_48 = 2'h1;
   localparam logic [1:0] CS_PRO_FS_44 = 2'h2;
   localparam logic [1:0] CS_PRO_FS_32 = 2'h3;
   localparam logic [3:0] CS_PRO_FS4_88 = 4'h9;
   localparam logic [3:0] CS_PRO_FS4_96 = 4'h5;

   typedef struct packed {
      logic wc_single;
      logic emphasis;
      logic professional;
      logic non_audio;
      logic spdif_opt_out;
      logic spdif_opt_in;
      logic [2:0] rate_sel;
      logic ext_ref;
   } dio_ctrl_t;

   typedef struct packed {
      logic double_speed;
      logic midi_act;
      logic fallback;
      logic wc_lock;
      logic [2:0] rate;
   } dio_status_t;

   typedef struct packed {
      logic [23:0] audio;
      logic validity;
      logic user;
      logic cs;
      logic chan_b;
   } dio_sub_t;

   typedef struct packed {
      logic [2:0] idx;
      logic phase;
      logic [23:0] data;
   } dio_slot_t;

endpackage

/* File: design/dio_cs_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module dio_cs_gen
   import dio_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Settings
   input wire dio_ctrl_t ctrl,
   input wire dio_rate_t rate,
   input wire logic [7:0] frame,
   // Status bit for the frame
   output logic cs_bit_q
);

   logic [39:0] v;
   logic [3:0] con_fs;
   logic [1:0] pro_fs;
   logic [3:0] pro_fs4;

   always_comb begin
      con_fs = CS_CON_FS_48;
      pro_fs = CS_PRO_FS_48;
      pro_fs4 = 4'h0;
      unique case (rate)
         RATE_32: begin
            con_fs = CS_CON_FS_32;
            pro_fs = CS_PRO_FS_32;
         end
         RATE_44: begin
            con_fs = CS_CON_FS_44;
            pro_fs = CS_PRO_FS_44;
         end
         RATE_48: begin
            con_fs = CS_CON_FS_48;
            pro_fs = CS_PRO_FS_48;
         end
         RATE_88: begin
            con_fs = CS_CON_FS_88;
            pro_fs = CS_PRO_FS_EXT;
            pro_fs4 = CS_PRO_FS4_88;
         end
         RATE_96: begin
            con_fs = CS_CON_FS_96;
            pro_fs = CS_PRO_FS_EXT;
            pro_fs4 = CS_PRO_FS4_96;
         end
         default: begin
            con_fs = CS_CON_FS_48;
         end
      endcase
   end

   // The block is built only from local settings, never from received status.
   always_comb begin
      v = '0;
      v[0] = ctrl.professional;
      v[1] = ctrl.non_audio;
      if (ctrl.professional) begin
         v[4:2] = ctrl.emphasis ? CS_PRO_EMPH_5015 : CS_PRO_EMPH_NONE;
         v[7:6] = pro_fs;
         v[11:8] = CS_PRO_MODE_2CH;
         v[18:16] = CS_PRO_AUX_AUDIO;
         v[38:35] = pro_fs4;
      end else begin
         v[2] = 1'b1;
         v[5:3] = ctrl.emphasis ? CS_CON_EMPH_5015 : CS_CON_EMPH_NONE;
         v[15:8] = CS_CAT_GENERAL;
         v[27:24] = con_fs;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_bit_q <= 1'b0;
      end else begin
         cs_bit_q <= (frame < 8'd40) ? v[frame[5:0]] : 1'b0;
      end
   end

endmodule
`default_nettype wire

/* File: design/dio_midi_act.sv */
`timescale 1ns/1ps
`default_nettype none
module dio_midi_act
   import dio_pkg::*;
#(
   parameter int unsigned HOLD_CYC = MIDI_HOLD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // MIDI input pin, idle high
   input wire logic midi_in,
   // Activity indicator
   output logic act_q
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic [19:0] hold_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= midi_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Every start bit retriggers, so short real-time messages light it too.
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= '0;
         act_q <= 1'b0;
      end else if (s3_q && !s2_q) begin
         hold_q <= 20'(HOLD_CYC);
         act_q <= 1'b1;
      end else if (hold_q != '0) begin
         hold_q <= hold_q - 20'd1;
         act_q <= (hold_q != 20'd1);
      end else begin
         act_q <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* File: design/dio_port.sv */
`timescale 1ns/1ps
`default_nettype none
module dio_port
   import dio_pkg::*;
#(
   parameter int unsigned WC_TIMEOUT = WC_TIMEOUT_CYC,
   parameter int unsigned MIDI_HOLD = MIDI_HOLD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite register slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Optical multichannel receive slots
   input wire logic opt_mc_valid,
   input wire dio_slot_t opt_mc_slot,
   // Receive subframes from optical and coaxial decoders
   input wire logic opt_sub_valid,
   input wire dio_sub_t opt_sub,
   input wire logic coax_sub_valid,
   input wire dio_sub_t coax_sub,
   // Received audio to the host side
   output logic rx_mc_valid,
   output dio_slot_t rx_mc,
   output logic rx_sub_valid,
   output dio_sub_t rx_sub,
   // Transmit audio from the host side
   input wire logic tx_mc_valid,
   input wire dio_slot_t tx_mc,
   input wire logic tx_sub_valid,
   input wire dio_sub_t tx_sub,
   // Transmit to encoders
   output logic opt_mc_out_valid,
   output dio_slot_t opt_mc_out,
   output logic opt_sub_out_valid,
   output dio_sub_t opt_sub_out,
   output logic coax_sub_out_valid,
   output dio_sub_t coax_sub_out,
   output logic tx_block_start,
   // Word clock, MIDI and analog control
   input wire logic wc_in,
   output logic wc_out,
   input wire logic midi_in,
   output logic midi_led,
   output logic deemph_en
);

   dio_ctrl_t ctrl_q;
   dio_rate_t meas_q;
   dio_rate_t rate;
   logic ds;
   logic wc_lock_q;
   logic midi_act;
   logic cs_bit;
   logic [7:0] frame_q;

   // Register slave. Address and data are taken in either order.
   logic aw_got_q;
   logic w_got_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   dio_status_t status;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awready && s_axi_awvalid) begin
         s_axi_awready <= 1'b0;
         aw_got_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         aw_got_q <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid && !s_axi_awready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_wready <= 1'b0;
         w_got_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wready && s_axi_wvalid) begin
         s_axi_wready <= 1'b0;
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         w_got_q <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid && !s_axi_wready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         ctrl_q <= CTRL_RST;
      end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q == REG_CTRL || awaddr_q == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
         // Settings change at once, also in the middle of playback.
         if (awaddr_q == REG_CTRL) begin
            if (wstrb_q[0]) begin
               ctrl_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
               ctrl_q[9:8] <= wdata_q[9:8];
            end
         end
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      status = '0;
      status.rate = rate;
      status.wc_lock = wc_lock_q;
      status.fallback = ctrl_q.ext_ref && !wc_lock_q;
      status.midi_act = midi_act;
      status.double_speed = ds;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
         if (s_axi_araddr == REG_CTRL) begin
            s_axi_rdata <= {22'h00_0000, ctrl_q};
         end else if (s_axi_araddr == REG_STATUS) begin
            s_axi_rdata <= {25'h000_0000, status};
         end else begin
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid && !s_axi_arready) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Word clock input: synchronise, then measure cycles between rising edges.
   logic wc1_q;
   logic wc2_q;
   logic wc3_q;
   logic [15:0] per_q;
   logic wc_rise;

   always_ff @(posedge clk) begin
      if (rst) begin
         wc1_q <= 1'b0;
         wc2_q <= 1'b0;
         wc3_q <= 1'b0;
      end else begin
         wc1_q <= wc_in;
         wc2_q <= wc1_q;
         wc3_q <= wc2_q;
      end
   end

   assign wc_rise = wc2_q && !wc3_q;

   // Either speed class is accepted, the period alone decides the rate.
   always_ff @(posedge clk) begin
      if (rst) begin
         per_q <= '0;
         meas_q <= RATE_48;
         wc_lock_q <= 1'b0;
      end else if (wc_rise) begin
         per_q <= 16'd1;
         if (per_q >= LIM_MIN && per_q < LIM_MAX) begin
            wc_lock_q <= 1'b1;
            if (per_q < LIM_96_88) begin
               meas_q <= RATE_96;
            end else if (per_q < LIM_88_48) begin
               meas_q <= RATE_88;
            end else if (per_q < LIM_48_44) begin
               meas_q <= RATE_48;
            end else if (per_q < LIM_44_32) begin
               meas_q <= RATE_44;
            end else begin
               meas_q <= RATE_32;
            end
         end else begin
            wc_lock_q <= 1'b0;
         end
      end else if (per_q >= 16'(WC_TIMEOUT)) begin
         // Reference lost: stay on the last matching standard rate as master.
         wc_lock_q <= 1'b0;
      end else begin
         per_q <= per_q + 16'd1;
      end
   end

   always_comb begin
      if (ctrl_q.ext_ref) begin
         rate = meas_q;
      end else begin
         unique case (ctrl_q.rate_sel)
            RATE_32: rate = RATE_32;
            RATE_44: rate = RATE_44;
            RATE_88: rate = RATE_88;
            RATE_96: rate = RATE_96;
            default: rate = RATE_48;
         endcase
      end
   end

   assign ds = (rate == RATE_88) || (rate == RATE_96);

   // Word clock output, free running at the current rate, or at half of it at double speed when wc_single is set.
   logic [15:0] half;
   logic [15:0] wc_cnt_q;

   always_comb begin
      unique case (rate)
         RATE_32: half = HALF_32;
         RATE_44: half = HALF_44;
         RATE_88: half = (ctrl_q.wc_single) ? HALF_44 : HALF_88;
         RATE_96: half = (ctrl_q.wc_single) ? HALF_48 : HALF_96;
         default: half = HALF_48;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wc_cnt_q <= '0;
         wc_out <= 1'b0;
      end else if (wc_cnt_q + 16'd1 >= half) begin
         wc_cnt_q <= '0;
         wc_out <= !wc_out;
      end else begin
         wc_cnt_q <= wc_cnt_q + 16'd1;
      end
   end

   // Receive side.
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_mc_valid <= 1'b0;
         rx_mc <= '0;
      end else begin
         rx_mc_valid <= opt_mc_valid && !ctrl_q.spdif_opt_in;
         rx_mc.data <= opt_mc_slot.data;
         if (ds) begin
            // Slot pairs carry alternate samples of one channel.
            rx_mc.idx <= {1'b0, opt_mc_slot.idx[2:1]};
            rx_mc.phase <= opt_mc_slot.idx[0];
         end else begin
            rx_mc.idx <= opt_mc_slot.idx;
            rx_mc.phase <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_sub_valid <= 1'b0;
         rx_sub <= '0;
      end else begin
         rx_sub_valid <= ctrl_q.spdif_opt_in ? opt_sub_valid : coax_sub_valid;
         rx_sub <= ctrl_q.spdif_opt_in ? opt_sub : coax_sub;
         rx_sub.cs <= 1'b0;
      end
   end

   // Transmit side. The frame counter walks the status block.
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_q <= '0;
      end else if (tx_sub_valid && tx_sub.chan_b) begin
         frame_q <= (frame_q == CS_BLOCK_LAST) ? 8'd0 : frame_q + 8'd1;
      end
   end

   dio_cs_gen u_cs (
      .clk(clk),
      .rst(rst),
      .ctrl(ctrl_q),
      .rate(rate),
      .frame(frame_q),
      .cs_bit_q(cs_bit)
   );

   dio_sub_t tx_out;

   always_comb begin
      tx_out = tx_sub;
      tx_out.cs = cs_bit;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         coax_sub_out_valid <= 1'b0;
         coax_sub_out <= '0;
         opt_sub_out_valid <= 1'b0;
         opt_sub_out <= '0;
         tx_block_start <= 1'b0;
      end else begin
         coax_sub_out_valid <= tx_sub_valid;
         coax_sub_out <= tx_out;
         opt_sub_out_valid <= tx_sub_valid && ctrl_q.spdif_opt_out;
         opt_sub_out <= tx_out;
         tx_block_start <= tx_sub_valid && !tx_sub.chan_b && frame_q == 8'd0;
      end
   end

   // At double speed only channels one to four go out, each over two slots.
   always_ff @(posedge clk) begin
      if (rst) begin
         opt_mc_out_valid <= 1'b0;
         opt_mc_out <= '0;
      end else begin
         opt_mc_out_valid <= tx_mc_valid && !ctrl_q.spdif_opt_out && !(ds && tx_mc.idx[2]);
         opt_mc_out.data <= tx_mc.data;
         opt_mc_out.phase <= 1'b0;
         opt_mc_out.idx <= ds ? {tx_mc.idx[1:0], tx_mc.phase} : tx_mc.idx;
      end
   end

   dio_midi_act #(
      .HOLD_CYC(MIDI_HOLD)
   ) u_midi (
      .clk(clk),
      .rst(rst),
      .midi_in(midi_in),
      .act_q(midi_act)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         midi_led <= 1'b0;
         deemph_en <= 1'b0;
      end else begin
         midi_led <= midi_act;
         deemph_en <= ctrl_q.emphasis;
      end
   end

endmodule
`default_nettype wire

/* File: tb/dio_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dio_port_asserts
   import dio_pkg::*;
(
   // Clock
   input wire logic clk,
   input wire logic rst,
   // Streams
   input wire logic opt_mc_valid,
   input wire logic opt_sub_valid,
   input wire logic coax_sub_valid,
   input wire logic rx_mc_valid,
   input wire logic rx_sub_valid,
   input wire dio_sub_t rx_sub,
   input wire logic tx_mc_valid,
   input wire logic tx_sub_valid,
   input wire dio_sub_t tx_sub,
   input wire logic opt_mc_out_valid,
   input wire logic opt_sub_out_valid,
   input wire dio_sub_t opt_sub_out,
   input wire logic coax_sub_out_valid,
   input wire dio_sub_t coax_sub_out,
   input wire logic tx_block_start,
   // Pins
   input wire logic wc_out,
   input wire logic midi_in,
   input wire logic midi_led
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   tx_audio_a: assert property (tx_sub_valid |=> coax_sub_out_valid && coax_sub_out.audio == $past(tx_sub.audio))
      else $error("transmit subframe lost");
   spdif_twin_a: assert property (opt_sub_out_valid |-> coax_sub_out_valid && opt_sub_out == coax_sub_out)
      else $error("optical and coaxial differ");
   rx_status_a: assert property (rx_sub_valid |-> !rx_sub.cs && $past(opt_sub_valid || coax_sub_valid))
      else $error("received status leaked");
   mc_rx_a: assert property (rx_mc_valid |-> $past(opt_mc_valid))
      else $error("spurious received slot");
   mc_tx_a: assert property (opt_mc_out_valid |-> $past(tx_mc_valid))
      else $error("spurious sent slot");
   blk_start_a: assert property (tx_block_start |-> coax_sub_out_valid && !coax_sub_out.chan_b)
      else $error("block start off frame");
   wc_running_a: assert property (1'b1 |-> ##[1:160] wc_out != $past(wc_out))
      else $error("word clock stalled");
   midi_seen_a: assert property ($fell(midi_in) |-> ##[1:4] midi_led)
      else $error("midi activity missed");
   cover property (tx_block_start);
   cover property (opt_sub_out_valid);
   cover property (rx_mc_valid && opt_mc_out_valid);
endmodule
bind dio_port dio_port_asserts u_chk (.clk, .rst, .opt_mc_valid, .opt_sub_valid, .coax_sub_valid, .rx_mc_valid,
   .rx_sub_valid, .rx_sub, .tx_mc_valid, .tx_sub_valid, .tx_sub, .opt_mc_out_valid, .opt_sub_out_valid,
   .opt_sub_out, .coax_sub_out_valid, .coax_sub_out, .tx_block_start, .wc_out, .midi_in, .midi_led);
`default_nettype wire

/* File: tb/dio_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dio_far_model (
   // Word clock source
   input wire logic wc_en,
   input wire logic [31:0] wc_half_ns,
   output logic wc_in,
   // MIDI sender
   input wire logic midi_go,
   input wire logic [7:0] midi_byte,
   output logic midi_in
);
   // The odd extra delay keeps the source unrelated in phase to the bench clock.
   initial begin
      wc_in = 1'b0;
      forever begin
         #(wc_half_ns + 32'h0000_0007);
         wc_in = wc_en ? !wc_in : 1'b0;
      end
   end
   initial begin
      midi_in = 1'b1;
      forever begin
         @(posedge midi_go);
         midi_in = 1'b0;
         #800;
         for (int i = 0; i < 8; i++) begin
            midi_in = midi_byte[i];
            #800;
         end
         midi_in = 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dio_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, got_w;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic opt_mc_valid = 1'b0, opt_sub_valid = 1'b0, coax_sub_valid = 1'b0, tx_mc_valid = 1'b0, tx_sub_valid = 1'b0;
   dio_slot_t opt_mc_slot = '0, tx_mc = '0, rx_mc, opt_mc_out;
   dio_sub_t opt_sub = '0, coax_sub = '0, tx_sub = '0, rx_sub, opt_sub_out, coax_sub_out;
   logic rx_mc_valid, rx_sub_valid, opt_mc_out_valid, opt_sub_out_valid, coax_sub_out_valid, tx_block_start;
   logic wc_in, wc_out, midi_in, midi_led, deemph_en, wc_en = 1'b0, midi_go = 1'b0;
   logic [31:0] wc_half_ns = 32'h0000_1458;
   logic [7:0] midi_byte = 8'h00;
   int comparisons = 0, miscompares = 0, fidx = 999, n_opt, n_coax;
   logic [3:0] cfs [5] = '{CS_CON_FS_32, CS_CON_FS_44, CS_CON_FS_48, CS_CON_FS_88, CS_CON_FS_96};
   logic [15:0] hlf [5] = '{HALF_32, HALF_44, HALF_48, HALF_88, HALF_96};
   always #50 clk = !clk;
   dio_port #(.WC_TIMEOUT(2000), .MIDI_HOLD(50)) u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .opt_mc_valid, .opt_mc_slot, .opt_sub_valid, .opt_sub, .coax_sub_valid, .coax_sub, .rx_mc_valid, .rx_mc,
      .rx_sub_valid, .rx_sub, .tx_mc_valid, .tx_mc, .tx_sub_valid, .tx_sub, .opt_mc_out_valid, .opt_mc_out,
      .opt_sub_out_valid, .opt_sub_out, .coax_sub_out_valid, .coax_sub_out, .tx_block_start, .wc_in, .wc_out,
      .midi_in, .midi_led, .deemph_en);
   dio_far_model u_far (.wc_en, .wc_half_ns, .wc_in, .midi_go, .midi_byte, .midi_in);
   // Frame count restarts at each block start, so only the first 32 status bits are kept.
   always @(posedge clk) begin
      if (coax_sub_out_valid === 1'b1 && coax_sub_out.chan_b === 1'b0) begin
         fidx = (tx_block_start === 1'b1) ? 0 : fidx + 1;
         if (fidx < 32) got_w[fidx] = coax_sub_out.cs;
      end
      n_opt += (opt_sub_out_valid === 1'b1);
      n_coax += (coax_sub_out_valid === 1'b1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic [1:0] r);
      int n;
      n = 0;
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 100);
      if (n >= 100) miscompares++;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   // Counts edges from one toggle to the next; the read lags the toggle by one edge.
   task automatic wch(output int n);
      logic v;
      @(wc_out);
      v = wc_out;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wc_out === v && n < 400);
   endtask
   initial begin
      #8_000_000;
      miscompares++;
      conclude();
   end
   initial begin
      dio_ctrl_t ctl;
      logic [31:0] d, e32;
      logic [1:0] rs;
      int n;
      logic ds, ev;
      dio_sub_t st, e;
      dio_sub_t po [2], pc [2];
      dio_slot_t ps [2], pt [2];
      void'($urandom(32'h3682_c731));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      axi(1'b0, REG_CTRL, '0, d, rs);
      chk(d, {22'h0, CTRL_RST});
      axi(1'b0, 4'h8, '0, d, rs);
      chk({d[29:0], rs}, {30'h0, RESP_SLVERR});
      for (int r = 0; r < 5; r++) begin
         ctl = dio_ctrl_t'(10'($urandom));
         ctl.ext_ref = 1'b0;
         ctl.rate_sel = 3'(r);
         ctl.professional = (r == 2);
         ctl.emphasis = r[0];
         ds = (r > 2);
         axi(1'b1, REG_CTRL, {22'h0, ctl}, d, rs);
         chk(rs, RESP_OKAY);
         axi(1'b0, REG_STATUS, '0, d, rs);
         chk({d[6], d[2:0]}, {ds, 3'(r)});
         chk(deemph_en, ctl.emphasis);
         wch(n);
         chk(n - 1, (ctl.wc_single && ds) ? hlf[r - 2] : hlf[r]);
         n_opt = 0;
         n_coax = 0;
         {opt_mc_valid, opt_sub_valid, coax_sub_valid, tx_mc_valid} <= 4'hf;
         for (int k = 0; k < 1600; k++) begin
            @(posedge clk);
            if (k > 1) begin
               e = ctl.spdif_opt_in ? po[1] : pc[1];
               e.cs = 1'b0;
               chk({rx_sub_valid, rx_sub}, {1'b1, e});
               chk(rx_mc_valid, !ctl.spdif_opt_in);
               if (!ctl.spdif_opt_in) chk({rx_mc.idx, rx_mc.phase, rx_mc.data}, {ds ? {1'b0, ps[1].idx[2:1]} : ps[1].idx, ds & ps[1].idx[0], ps[1].data});
               ev = !ctl.spdif_opt_out && !(ds && pt[1].idx[2]);
               chk(opt_mc_out_valid, ev);
               if (ev) chk({opt_mc_out.idx, opt_mc_out.phase, opt_mc_out.data}, {ds ? {pt[1].idx[1:0], pt[1].phase} : pt[1].idx, 1'b0, pt[1].data});
            end
            po[1] = po[0];
            pc[1] = pc[0];
            ps[1] = ps[0];
            pt[1] = pt[0];
            po[0] = 28'($urandom);
            pc[0] = 28'($urandom);
            po[0].cs = 1'b1;
            pc[0].cs = 1'b1;
            ps[0] = 28'($urandom);
            pt[0] = 28'($urandom);
            st = 28'($urandom);
            st.chan_b = k[1];
            opt_sub <= po[0];
            coax_sub <= pc[0];
            opt_mc_slot <= ps[0];
            tx_mc <= pt[0];
            tx_sub <= st;
            tx_sub_valid <= !k[0];
         end
         {opt_mc_valid, opt_sub_valid, coax_sub_valid, tx_mc_valid, tx_sub_valid} <= '0;
         repeat (3) @(posedge clk);
         chk(n_opt, ctl.spdif_opt_out ? n_coax : 0);
         e32 = {4'h0, cfs[r], 18'h0, ctl.emphasis ? CS_CON_EMPH_5015 : CS_CON_EMPH_NONE, 1'b1, ctl.non_audio, 1'b0};
         if (ctl.professional) chk(got_w[1:0], {ctl.non_audio, 1'b1});
         else chk(got_w, e32);
      end
      ctl = '0;
      ctl.ext_ref = 1'b1;
      axi(1'b1, REG_CTRL, {22'h0, ctl}, d, rs);
      wc_en <= 1'b1;
      for (int j = 0; j < 2; j++) begin
         wc_half_ns <= j ? 32'h0000_2c49 : 32'h0000_1458;
         repeat (20) @(posedge wc_in);
         @(posedge clk);
         axi(1'b0, REG_STATUS, '0, d, rs);
         chk({d[6], d[4:0]}, j ? {3'b001, RATE_44} : {3'b101, RATE_96});
      end
      wc_en <= 1'b0;
      repeat (2300) @(posedge clk);
      axi(1'b0, REG_STATUS, '0, d, rs);
      chk(d[4:0], {2'b10, RATE_44});
      midi_byte <= 8'($urandom);
      midi_go <= 1'b1;
      n = 0;
      while (midi_led !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk(midi_led, 1'b1);
      midi_go <= 1'b0;
      conclude();
   end
endmodule
`default_nettype wire
